// ===== core/smap_map.svh
`ifndef SMAP_MAP_SVH
`define SMAP_MAP_SVH

// ==================================================
// Widths and address field bases
`define SMAP_ADDR_W        28
`define SMAP_DQ_W          16
`define SMAP_A_W           13
`define SMAP_COL_BASE      8
`define SMAP_ROW_BASE      11
`define SMAP_A_PREALL      10
`define SMAP_CAS_LAT_DEF   2

// ==================================================
// Command mode field codes
`define SMAP_MODE_NORMAL   3'h0
`define SMAP_MODE_NOP      3'h1
`define SMAP_MODE_PALL     3'h2
`define SMAP_MODE_LMR      3'h3
`define SMAP_MODE_REF      3'h4
`define SMAP_MODE_ELMR     3'h5

// ==================================================
// Pin commands as {chip select, row strobe, column strobe, write enable}
`define SMAP_CMD_NOP       4'h7
`define SMAP_CMD_ACT       4'h3
`define SMAP_CMD_RD        4'h5
`define SMAP_CMD_WR        4'h4
`define SMAP_CMD_PRE       4'h2
`define SMAP_CMD_REF       4'h1
`define SMAP_CMD_LMR       4'h0
`define SMAP_CMD_DESEL     4'hf

`endif

// ===== core/smap_pkg.sv
package smap_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ACT  = 3'h1,
        ST_RW   = 3'h3,
        ST_PRE  = 3'h2,
        ST_DONE = 3'h6
    } smap_state_e;

    typedef logic [3:0] smap_cmd_t;

endpackage

// ===== core/smap_sync.sv
`timescale 1ns/100ps
`default_nettype none

// A change on d_i is passed on only once the second and third stages agree.
module smap_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic d_i,
    output logic      q_o
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_nxt;

    always_comb begin
        q_nxt = (s2_r == s3_r) ? s3_r : q_o;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_o  <= q_nxt;
        end
    end

endmodule
`default_nettype wire

// ===== core/smap_top.sv
`include "smap_map.svh"
`timescale 1ns/100ps
`default_nettype none

module smap_top
    import smap_pkg::*;
#(
    parameter int CAS_LAT = `SMAP_CAS_LAT_DEF
) (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        mem_clk_i,
    input  wire logic        req_valid_i,
    input  wire logic        req_write_i,
    input  wire logic        req_byte_i,
    input  wire logic [27:0] req_addr_i,
    input  wire logic [15:0] req_wdata_i,
    input  wire logic [1:0]  cfg_cols_i,
    input  wire logic [1:0]  cfg_rows_i,
    input  wire logic        cfg_four_banks_i,
    input  wire logic [2:0]  command_mode_field_i,
    input  wire logic        refresh_tick_i,
    input  wire logic        status_read_i,
    output logic             req_ready_o,
    output logic             rsp_valid_o,
    output logic [15:0]      rsp_rdata_o,
    output logic             refresh_error_flag_o,
    output logic             irq_o,
    output logic             memory_clock_out_o,
    output logic             memory_clock_enable_out_o,
    output logic             memory_chip_select_n_o,
    output logic             row_strobe_n_o,
    output logic             col_strobe_n_o,
    output logic             memory_write_enable_n_o,
    output logic [1:0]       bank_select_o,
    output logic [1:0]       byte_mask_o,
    output logic [12:0]      mem_address_out_o,
    input  wire logic [15:0] dq_i,
    output logic [15:0]      dq_o,
    output logic             dq_oe_o
);

    if (CAS_LAT < 1 || CAS_LAT > 3) begin : g_bad_cas
        $error("CAS_LAT must be 1, 2 or 3");
    end

    // ==================================================
    // Bus side: address split and request hand-off
    logic        ready_r, ready_nxt, rsp_valid_nxt;
    logic [15:0] rdata_nxt;
    logic        req_tog_r, req_tog_nxt, ack_seen_r, ack_seen_nxt;
    logic        h_write_r, h_write_nxt;
    logic [2:0]  h_mode_r, h_mode_nxt;
    logic [10:0] h_col_r, h_col_nxt;
    logic [12:0] h_row_r, h_row_nxt;
    logic [1:0]  h_bank_r, h_bank_nxt, h_dqm_r, h_dqm_nxt;
    logic [15:0] h_wdata_r, h_wdata_nxt;
    logic        pend_r, pend_nxt, rf_tog_r, rf_tog_nxt, rf_seen_r, rf_seen_nxt;
    logic        err_nxt, take, done, rf_done, miss;
    logic [1:0]  rsel;
    logic [3:0]  col_w, row_w;
    logic [27:0] above_col;
    logic        ack_s, rfa_s;
    logic [15:0] rd_r;
    logic        ack_tog_r, ack_tog_nxt, rfa_tog_r, rfa_tog_nxt;

    smap_sync u_ack_sync (.clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(ack_tog_r), .q_o(ack_s));
    smap_sync u_rfa_sync (.clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(rfa_tog_r), .q_o(rfa_s));

    always_comb begin
        take      = req_valid_i && ready_r;
        done      = ack_s != ack_seen_r;
        rsel      = (cfg_rows_i == 2'h3) ? 2'h2 : cfg_rows_i;
        col_w     = 4'(`SMAP_COL_BASE) + {2'h0, cfg_cols_i};
        row_w     = 4'(`SMAP_ROW_BASE) + {2'h0, rsel};
        above_col = req_addr_i >> (col_w + 4'h1);
        h_col_nxt  = h_col_r;
        h_row_nxt  = h_row_r;
        h_bank_nxt = h_bank_r;
        h_dqm_nxt  = h_dqm_r;
        h_wdata_nxt = h_wdata_r;
        h_write_nxt = h_write_r;
        h_mode_nxt  = h_mode_r;
        req_tog_nxt = req_tog_r;
        ready_nxt   = ready_r;
        if (take) begin
            // Bit 0 never reaches the column; it only chooses the lane.
            h_col_nxt  = req_addr_i[11:1] & ~(11'h7ff << col_w);
            h_row_nxt  = above_col[12:0] & ~(13'h1fff << row_w);
            h_bank_nxt = 2'(above_col >> row_w);
            if (!cfg_four_banks_i) begin
                h_bank_nxt[1] = 1'b0;
            end
            h_dqm_nxt   = !req_byte_i ? 2'h0 : (req_addr_i[0] ? 2'h1 : 2'h2);
            h_wdata_nxt = req_byte_i ? {2{req_wdata_i[7:0]}} : req_wdata_i;
            h_write_nxt = req_write_i;
            h_mode_nxt  = command_mode_field_i;
            req_tog_nxt = !req_tog_r;
            ready_nxt   = 1'b0;
        end else if (done) begin
            ready_nxt = 1'b1;
        end
        ack_seen_nxt  = done ? ack_s : ack_seen_r;
        rsp_valid_nxt = done;
        rdata_nxt     = done ? rd_r : rsp_rdata_o;
        // A new tick while the last refresh is still waiting means one was lost.
        rf_done     = rfa_s != rf_seen_r;
        rf_seen_nxt = rf_done ? rfa_s : rf_seen_r;
        miss        = refresh_tick_i && pend_r && !rf_done;
        pend_nxt    = (refresh_tick_i && !miss) ? 1'b1 : (rf_done ? 1'b0 : pend_r);
        rf_tog_nxt  = (refresh_tick_i && !miss) ? !rf_tog_r : rf_tog_r;
        // Set wins over the read that clears it.
        err_nxt = miss ? 1'b1 : (status_read_i ? 1'b0 : refresh_error_flag_o);
    end

    // The bus side runs from reset on; gating its clock is left to software.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_r <= 1'b1;
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 16'h0000;
            req_tog_r <= 1'b0;
            ack_seen_r <= 1'b0;
            h_write_r <= 1'b0;
            h_mode_r <= `SMAP_MODE_NORMAL;
            h_col_r <= 11'h000;
            h_row_r <= 13'h0000;
            h_bank_r <= 2'h0;
            h_dqm_r <= 2'h0;
            h_wdata_r <= 16'h0000;
            pend_r <= 1'b0;
            rf_tog_r <= 1'b0;
            rf_seen_r <= 1'b0;
            refresh_error_flag_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            ready_r <= ready_nxt;
            req_ready_o <= ready_nxt;
            rsp_valid_o <= rsp_valid_nxt;
            rsp_rdata_o <= rdata_nxt;
            req_tog_r <= req_tog_nxt;
            ack_seen_r <= ack_seen_nxt;
            h_write_r <= h_write_nxt;
            h_mode_r <= h_mode_nxt;
            h_col_r <= h_col_nxt;
            h_row_r <= h_row_nxt;
            h_bank_r <= h_bank_nxt;
            h_dqm_r <= h_dqm_nxt;
            h_wdata_r <= h_wdata_nxt;
            pend_r <= pend_nxt;
            rf_tog_r <= rf_tog_nxt;
            rf_seen_r <= rf_seen_nxt;
            refresh_error_flag_o <= err_nxt;
            irq_o <= err_nxt;
        end
    end

    take_busy_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        req_valid_i && req_ready_o |=> !req_ready_o);
    col_2k_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        take && cfg_cols_i == 2'h0 && cfg_rows_i == 2'h0
        |=> h_col_r == {3'h0, $past(req_addr_i[8:1])} && h_row_r[10:0] == $past(req_addr_i[19:9]));
    row_4k_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        take && cfg_cols_i == 2'h1 && cfg_rows_i == 2'h1
        |=> h_row_r == {1'b0, $past(req_addr_i[21:10])});
    bank_8k_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        take && cfg_cols_i == 2'h3 && cfg_rows_i == 2'h2 && cfg_four_banks_i
        |=> h_bank_r == $past(req_addr_i[26:25]));
    lost_refresh_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        miss |=> refresh_error_flag_o ##0 irq_o);
    irq_clear_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        status_read_i && !miss |=> !irq_o && !refresh_error_flag_o);

    // ==================================================
    // Memory side: command sequencing on the link clock
    smap_state_e st_r, st_nxt;
    logic       req_s, rf_s, req_seen_r, req_seen_nxt, mrf_seen_r, mrf_seen_nxt;
    logic       is_ref_r, is_ref_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [15:0] rd_nxt;
    smap_cmd_t  cmd_nxt;
    logic [1:0] ba_nxt, dqm_nxt;
    logic [12:0] a_nxt;
    logic [15:0] dq_nxt;
    logic       oe_nxt;

    smap_sync u_req_sync (.clk_i(mem_clk_i), .nrst_i(nrst_i), .d_i(req_tog_r), .q_o(req_s));
    smap_sync u_rf_sync (.clk_i(mem_clk_i), .nrst_i(nrst_i), .d_i(rf_tog_r), .q_o(rf_s));

    // Commands advance only while the memory clock is high, so pins settle
    // on its falling edge and are sampled on the next rising one.
    always_comb begin
        st_nxt = st_r;
        req_seen_nxt = req_seen_r;
        mrf_seen_nxt = mrf_seen_r;
        ack_tog_nxt = ack_tog_r;
        rfa_tog_nxt = rfa_tog_r;
        is_ref_nxt = is_ref_r;
        cnt_nxt = cnt_r;
        rd_nxt = rd_r;
        cmd_nxt = {memory_chip_select_n_o, row_strobe_n_o, col_strobe_n_o, memory_write_enable_n_o};
        ba_nxt = bank_select_o;
        a_nxt = mem_address_out_o;
        dqm_nxt = byte_mask_o;
        dq_nxt = dq_o;
        oe_nxt = dq_oe_o;
        if (memory_clock_out_o) begin
            cmd_nxt = `SMAP_CMD_NOP;
            oe_nxt = 1'b0;
            dqm_nxt = 2'h0;
            case (st_r)
                ST_IDLE: begin
                    if (rf_s != mrf_seen_r) begin
                        mrf_seen_nxt = rf_s;
                        cmd_nxt = `SMAP_CMD_REF;
                        is_ref_nxt = 1'b1;
                        st_nxt = ST_DONE;
                    end else if (req_s != req_seen_r) begin
                        req_seen_nxt = req_s;
                        is_ref_nxt = 1'b0;
                        ba_nxt = h_bank_r;
                        a_nxt = h_row_r;
                        st_nxt = ST_DONE;
                        if (!h_write_r || h_mode_r == `SMAP_MODE_NORMAL) begin
                            cmd_nxt = `SMAP_CMD_ACT;
                            st_nxt = ST_ACT;
                        end else begin
                            case (h_mode_r)
                                `SMAP_MODE_PALL: begin
                                    cmd_nxt = `SMAP_CMD_PRE;
                                    a_nxt[`SMAP_A_PREALL] = 1'b1;
                                end
                                `SMAP_MODE_LMR: cmd_nxt = `SMAP_CMD_LMR;
                                `SMAP_MODE_ELMR: cmd_nxt = `SMAP_CMD_LMR;
                                `SMAP_MODE_REF: cmd_nxt = `SMAP_CMD_REF;
                                default: cmd_nxt = `SMAP_CMD_NOP;
                            endcase
                        end
                    end
                end
                ST_ACT: begin
                    cmd_nxt = h_write_r ? `SMAP_CMD_WR : `SMAP_CMD_RD;
                    // A10 stays low: auto precharge is never used.
                    a_nxt = {1'b0, h_col_r[10], 1'b0, h_col_r[9:0]};
                    dqm_nxt = h_dqm_r;
                    dq_nxt = h_wdata_r;
                    oe_nxt = h_write_r;
                    cnt_nxt = h_write_r ? 2'h0 : 2'(CAS_LAT - 1);
                    st_nxt = ST_RW;
                end
                ST_RW: begin
                    dqm_nxt = h_write_r ? 2'h0 : h_dqm_r;
                    if (cnt_r != 2'h0) begin
                        cnt_nxt = cnt_r - 2'h1;
                    end else begin
                        rd_nxt = h_write_r ? rd_r : dq_i;
                        st_nxt = ST_PRE;
                    end
                end
                ST_PRE: begin
                    cmd_nxt = `SMAP_CMD_PRE;
                    a_nxt[`SMAP_A_PREALL] = 1'b1;
                    st_nxt = ST_DONE;
                end
                ST_DONE: begin
                    ack_tog_nxt = is_ref_r ? ack_tog_r : !ack_tog_r;
                    rfa_tog_nxt = is_ref_r ? !rfa_tog_r : rfa_tog_r;
                    st_nxt = ST_IDLE;
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mem_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= ST_IDLE;
            req_seen_r <= 1'b0;
            mrf_seen_r <= 1'b0;
            ack_tog_r <= 1'b0;
            rfa_tog_r <= 1'b0;
            is_ref_r <= 1'b0;
            cnt_r <= 2'h0;
            rd_r <= 16'h0000;
            memory_clock_out_o <= 1'b0;
            memory_clock_enable_out_o <= 1'b0;
            {memory_chip_select_n_o, row_strobe_n_o, col_strobe_n_o,
             memory_write_enable_n_o} <= `SMAP_CMD_DESEL;
            bank_select_o <= 2'h0;
            mem_address_out_o <= 13'h0000;
            byte_mask_o <= 2'h0;
            dq_o <= 16'h0000;
            dq_oe_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            req_seen_r <= req_seen_nxt;
            mrf_seen_r <= mrf_seen_nxt;
            ack_tog_r <= ack_tog_nxt;
            rfa_tog_r <= rfa_tog_nxt;
            is_ref_r <= is_ref_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            memory_clock_out_o <= !memory_clock_out_o;
            memory_clock_enable_out_o <= 1'b1;
            {memory_chip_select_n_o, row_strobe_n_o, col_strobe_n_o,
             memory_write_enable_n_o} <= cmd_nxt;
            bank_select_o <= ba_nxt;
            mem_address_out_o <= a_nxt;
            byte_mask_o <= dqm_nxt;
            dq_o <= dq_nxt;
            dq_oe_o <= oe_nxt;
        end
    end

    act_row_a: assert property (@(posedge mem_clk_i) disable iff (!nrst_i)
        {memory_chip_select_n_o, row_strobe_n_o, col_strobe_n_o,
         memory_write_enable_n_o} == `SMAP_CMD_ACT && !memory_clock_out_o
        |-> mem_address_out_o == h_row_r && bank_select_o == h_bank_r);
    act_then_rw_a: assert property (@(posedge mem_clk_i) disable iff (!nrst_i)
        $rose(st_r == ST_ACT) |-> ##2 !col_strobe_n_o && row_strobe_n_o
        && mem_address_out_o[9:0] == h_col_r[9:0]);
    write_lane_a: assert property (@(posedge mem_clk_i) disable iff (!nrst_i)
        dq_oe_o |-> !memory_write_enable_n_o && !memory_chip_select_n_o
        && byte_mask_o == h_dqm_r && dq_o == h_wdata_r);
    cke_high_a: assert property (@(posedge mem_clk_i) disable iff (!nrst_i)
        $past(nrst_i) |-> memory_clock_enable_out_o);

endmodule
`default_nettype wire

// ===== verif/smap_sdram_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "smap_map.svh"

// Behavioural memory part: commands are sampled on the rising memory clock.
// Between bursts the data lines carry a toggling pattern so that a stale
// capture by the controller cannot pass for real read data.
module smap_sdram_model #(
    parameter int CAS_LAT = 2
) (
    input  wire logic        clk_i,
    input  wire logic        cke_i,
    input  wire logic [3:0]  cmd_i,
    input  wire logic [1:0]  ba_i,
    input  wire logic [12:0] a_i,
    input  wire logic [1:0]  dqm_i,
    input  wire logic [15:0] dq_in_i,
    input  wire logic        dq_oe_i,
    output logic [15:0]      dq_o
);
    logic [15:0] mem [logic [25:0]];
    logic [1:0]  act_ba   = 2'h0;
    logic [12:0] act_row  = 13'h0;
    logic [12:0] rw_a     = 13'h0;
    logic [1:0]  rw_mask  = 2'h0;
    logic [3:0]  last_cmd = 4'hf;
    logic [1:0]  last_ba  = 2'h0;
    logic [12:0] last_a   = 13'h0;
    logic [15:0] rd_q     = 16'h0;
    logic [15:0] idle_pat = 16'h5a5a;
    int          rd_cnt   = 0;
    int          ref_cnt  = 0;
    logic [25:0] key;
    logic [15:0] old;

    assign dq_o = (rd_cnt == 1) ? rd_q : idle_pat;

    always @(posedge clk_i) begin
        idle_pat <= ~idle_pat;
        rd_cnt <= (rd_cnt > 0) ? rd_cnt - 1 : 0;
        key = {act_ba, act_row, a_i[11], a_i[9:0]};
        old = mem.exists(key) ? mem[key] : ~key[15:0];
        if (cke_i && !cmd_i[3]) begin
            last_cmd <= cmd_i;
            last_ba <= ba_i;
            last_a <= a_i;
            case (cmd_i)
                `SMAP_CMD_ACT: begin
                    act_ba <= ba_i;
                    act_row <= a_i;
                end
                `SMAP_CMD_RD: begin
                    rw_a <= a_i;
                    rw_mask <= dqm_i;
                    rd_q <= old;
                    rd_cnt <= CAS_LAT;
                end
                `SMAP_CMD_WR: begin
                    rw_a <= a_i;
                    rw_mask <= dqm_i;
                    mem[key] = {dqm_i[1] ? old[15:8] : dq_in_i[15:8],
                                dqm_i[0] ? old[7:0] : dq_in_i[7:0]};
                end
                `SMAP_CMD_REF: ref_cnt <= ref_cnt + 1;
                default: ;
            endcase
        end
    end
endmodule

`default_nettype wire

// ===== verif/sdram_pin_and_address_mapper_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "smap_map.svh"

module sdram_pin_and_address_mapper_tb;
    localparam int CAS = 3;
    logic ref_clk_i = 1'b0;
    logic mem_clk_i = 1'b0;
    logic nrst_i, req_valid_i, req_write_i, req_byte_i, cfg_four_banks_i;
    logic refresh_tick_i, status_read_i;
    logic [27:0] req_addr_i;
    logic [15:0] req_wdata_i, rsp_rdata_o, dq_o, mdl_dq, dq_bus, last_rdata;
    logic [1:0]  cfg_cols_i, cfg_rows_i, bank_select_o, byte_mask_o;
    logic [2:0]  command_mode_field_i;
    logic [12:0] mem_address_out_o;
    logic req_ready_o, rsp_valid_o, refresh_error_flag_o, irq_o, dq_oe_o, mclk_o, cke_o;
    logic cs_n, ras_n, cas_n, we_n;
    int   bad_count = 0;
    int   n_checks = 0;
    int   refs;
    logic [27:0] a;
    logic [15:0] d;
    logic [7:0]  b;

    always #5 ref_clk_i = ~ref_clk_i;
    initial begin
        #13;
        forever #32 mem_clk_i = ~mem_clk_i;
    end
    assign dq_bus = dq_oe_o ? dq_o : mdl_dq;

    smap_top #(.CAS_LAT(CAS)) DUT (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .mem_clk_i(mem_clk_i),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_byte_i(req_byte_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .cfg_cols_i(cfg_cols_i),
        .cfg_rows_i(cfg_rows_i), .cfg_four_banks_i(cfg_four_banks_i),
        .command_mode_field_i(command_mode_field_i), .refresh_tick_i(refresh_tick_i),
        .status_read_i(status_read_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .refresh_error_flag_o(refresh_error_flag_o),
        .irq_o(irq_o), .memory_clock_out_o(mclk_o), .memory_clock_enable_out_o(cke_o),
        .memory_chip_select_n_o(cs_n), .row_strobe_n_o(ras_n), .col_strobe_n_o(cas_n),
        .memory_write_enable_n_o(we_n), .bank_select_o(bank_select_o),
        .byte_mask_o(byte_mask_o), .mem_address_out_o(mem_address_out_o),
        .dq_i(dq_bus), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

    smap_sdram_model #(.CAS_LAT(CAS)) u_mem (
        .clk_i(mclk_o), .cke_i(cke_o), .cmd_i({cs_n, ras_n, cas_n, we_n}),
        .ba_i(bank_select_o), .a_i(mem_address_out_o), .dqm_i(byte_mask_o),
        .dq_in_i(dq_bus), .dq_oe_i(dq_oe_o), .dq_o(mdl_dq));

    // ==================================================
    // Checking and reporting
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_val(what, {15'h0, exp}, {15'h0, got});
    endtask

    // Returns {bank, row, column} as the address split should produce them.
    function automatic logic [25:0] exp_map(input logic [27:0] ad);
        int          cb;
        int          rb;
        logic [27:0] s;
        cb = 8 + int'(cfg_cols_i);
        rb = 11 + ((cfg_rows_i == 2'h0) ? 0 : (cfg_rows_i == 2'h1) ? 1 : 2);
        s = ad >> 1;
        exp_map[10:0] = 11'(s & ((28'h1 << cb) - 28'h1));
        s = s >> cb;
        exp_map[23:11] = 13'(s & ((28'h1 << rb) - 28'h1));
        exp_map[25:24] = 2'(s >> rb) & {cfg_four_banks_i, 1'b1};
    endfunction

    function automatic logic [3:0] mode_cmd(input int m);
        case (m)
            2: mode_cmd = `SMAP_CMD_PRE;
            3, 5: mode_cmd = `SMAP_CMD_LMR;
            4: mode_cmd = `SMAP_CMD_REF;
            default: mode_cmd = `SMAP_CMD_NOP;
        endcase
    endfunction

    // ==================================================
    // Bus requests: held until taken, then wait for the response pulse.
    task automatic access(input logic wr, input logic bt, input logic [27:0] ad,
                          input logic [15:0] wd, input logic [2:0] m);
        int n;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        req_write_i <= wr;
        req_byte_i <= bt;
        req_addr_i <= ad;
        req_wdata_i <= wd;
        command_mode_field_i <= m;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 400);
        req_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (rsp_valid_o !== 1'b1 && n < 400);
        chk_bit("response", 1'b1, rsp_valid_o);
        last_rdata = rsp_rdata_o;
    endtask

    task automatic check_map(input logic [27:0] ad, input logic [1:0] mask);
        logic [25:0] e;
        e = exp_map(ad);
        chk_val("bank", 16'(e[25:24]), 16'(u_mem.act_ba));
        chk_val("row", 16'(e[23:11]), 16'(u_mem.act_row));
        chk_val("column", 16'(e[10:0]), {5'h0, u_mem.rw_a[11], u_mem.rw_a[9:0]});
        chk_val("byte mask", 16'(mask), 16'(u_mem.rw_mask));
    endtask

    task automatic tick(input logic clr);
        @(posedge ref_clk_i);
        refresh_tick_i <= 1'b1;
        status_read_i <= clr;
        @(posedge ref_clk_i);
        refresh_tick_i <= 1'b0;
        status_read_i <= 1'b0;
    endtask

    initial begin
        repeat (80000) @(posedge ref_clk_i);
        bad_count++;
        test_done();
    end

    // ==================================================
    // Main sequence
    initial begin
        {nrst_i, req_valid_i, req_write_i, req_byte_i, refresh_tick_i, status_read_i} = 6'h0;
        {req_addr_i, req_wdata_i, command_mode_field_i} = 47'h0;
        {cfg_cols_i, cfg_rows_i, cfg_four_banks_i} = 5'h1;
        void'($urandom(41835));
        repeat (8) @(posedge ref_clk_i);
        chk_bit("cs_n in reset", 1'b1, cs_n);
        chk_bit("cke in reset", 1'b0, cke_o);
        chk_bit("oe in reset", 1'b0, dq_oe_o);
        nrst_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        chk_bit("ready after reset", 1'b1, req_ready_o);
        chk_bit("cke after reset", 1'b1, cke_o);
        for (int m = 1; m < 8; m++) begin
            a = 28'($urandom);
            access(1'b1, 1'b0, a, 16'h0, 3'(m));
            chk_val("mode command", 16'(mode_cmd(m)), 16'(u_mem.last_cmd));
            if (m == 2)
                chk_bit("precharge all A10", 1'b1, u_mem.last_a[10]);
            if (m == 3 || m == 5)
                chk_val("mode bank", 16'(exp_map(a) >> 24), 16'(u_mem.last_ba));
        end
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                cfg_cols_i <= 2'(c);
                cfg_rows_i <= 2'(r);
                cfg_four_banks_i <= (r != 1);
                a = (c == 3 && r == 2) ? 28'hfffffff : 28'($urandom);
                d = 16'($urandom);
                b = 8'($urandom);
                access(1'b1, 1'b0, a, d, 3'h0);
                check_map(a, 2'b00);
                access(1'b1, 1'b1, a, {8'h0, b}, 3'h0);
                check_map(a, a[0] ? 2'b01 : 2'b10);
                access(1'b0, 1'b0, a, 16'h0, 3'h0);
                check_map(a, 2'b00);
                chk_val("read data", a[0] ? {b, d[7:0]} : {d[15:8], b}, last_rdata);
            end
        end
        refs = u_mem.ref_cnt;
        tick(1'b0);
        repeat (200) @(posedge ref_clk_i);
        chk_val("refresh count", 16'(refs + 1), 16'(u_mem.ref_cnt));
        chk_bit("no refresh error", 1'b0, refresh_error_flag_o);
        tick(1'b0);
        tick(1'b0);
        repeat (3) @(posedge ref_clk_i);
        chk_bit("refresh error", 1'b1, refresh_error_flag_o);
        chk_bit("interrupt", 1'b1, irq_o);
        repeat (200) @(posedge ref_clk_i);
        tick(1'b0);
        tick(1'b1);
        repeat (3) @(posedge ref_clk_i);
        chk_bit("set wins clear", 1'b1, refresh_error_flag_o);
        repeat (200) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        status_read_i <= 1'b1;
        @(posedge ref_clk_i);
        status_read_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk_bit("error cleared", 1'b0, refresh_error_flag_o);
        chk_bit("interrupt cleared", 1'b0, irq_o);
        // The run never resets or gates the clock in mid-command.
        test_done();
    end
endmodule

`default_nettype wire
